//--- src/omp_consts.svh
// Offsets, field positions, reset values and counts of the output mode control.
// Assumes inclusion by bare name from the package and the control module.
`ifndef OMP_CONSTS_SVH
`define OMP_CONSTS_SVH
// Register byte addresses
`define OMP_CTRL_ADDR 4'h0
`define OMP_STAT_ADDR 4'h4
// Control word field positions
`define OMP_F_RANGE_HI 10
`define OMP_F_RANGE_LO 7
`define OMP_F_CLS 6
`define OMP_F_OEN 5
`define OMP_F_CLR 4
`define OMP_F_SENSE_RESISTOR_SELECT 3
`define OMP_F_RST 2
// Writable control bits
`define OMP_CTRL_MASK 16'h07F8
`define OMP_CTRL_RESET 16'h0000
// Range codes
`define OMP_RNG_V5 4'h0
`define OMP_RNG_V10 4'h1
`define OMP_RNG_V40 4'h2
`define OMP_RNG_I4_20 4'h4
`define OMP_RNG_I0_20 4'h5
`define OMP_RNG_I0_24 4'h6
// Cycles after reset release before straps are caught
`define OMP_CAPTURE_DLY 2'h3
// Bus responses
`define OMP_RESP_OKAY 2'h0
`define OMP_RESP_SLVERR 2'h2
`endif

//--- src/omp_ctrl.sv
// Output mode, range and power-on control of a voltage/current output driver.
// Assumes an AXI4-Lite master on clk; all pins are asynchronous and synchronised.
`timescale 1ns/1ns
`include "omp_consts.svh"
module omp_ctrl
    import omp_pkg::*;
(
    // Clock and power-on reset
    input wire logic clk,
    input wire logic nrst,
    // AXI4-Lite write
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Configuration pins
    input wire logic mode_select_pin,
    input wire logic [3:0] range_select,
    input wire logic output_enable,
    input wire logic clear_pin,
    input wire logic clear_level_select,
    input wire logic reset_pin_n,
    // Output stage controls
    output logic voltage_output_pin,
    output logic voltage_zero,
    output logic current_output_pin,
    output logic clear_state,
    output logic [3:0] out_range,
    output logic sense_resistor_select,
    output logic mode_hw
);
    // Synchroniser stages: first stage is read only by the second
    logic [8:0] sync1_r;
    logic [8:0] sync2_r;
    // Control and state
    omp_ctrl_t ctrl_r;
    logic [1:0] cap_cnt_r;
    logic captured_r;
    logic mode_hw_r;
    logic pwrup_clr_r;
    logic started_r;
    logic voltage_output_pin_r;
    logic vzero_r;
    logic current_output_pin_r;
    logic clrst_r;
    omp_range_t range_r;
    logic sense_resistor_select_r;
    // Bus state
    logic aw_got_r;
    logic w_got_r;
    logic [3:0] waddr_r;
    logic [31:0] wdata_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    // Lane enables of the captured write: partial writes are ignored
    logic [3:0] wstrb_r;

    // Two-flop synchronisers for every pin
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_r <= 9'h000;
            sync2_r <= 9'h000;
        end
        else
        begin
            sync1_r <= {reset_pin_n, clear_level_select, clear_pin, output_enable, range_select, mode_select_pin};
            sync2_r <= sync1_r;
        end
    end

    // Synchronised pin levels
    wire s_mode = sync2_r[0];
    wire [3:0] s_range = sync2_r[4:1];
    wire s_oen = sync2_r[5];
    wire s_clr = sync2_r[6];
    wire s_cls = sync2_r[7];
    wire s_rst_n = sync2_r[8];

    // Software control fields
    wire [3:0] c_range = ctrl_r[`OMP_F_RANGE_HI:`OMP_F_RANGE_LO];
    wire c_cls = ctrl_r[`OMP_F_CLS];
    wire c_oen = ctrl_r[`OMP_F_OEN];
    wire c_clr = ctrl_r[`OMP_F_CLR];
    wire c_sense_resistor_select = ctrl_r[`OMP_F_SENSE_RESISTOR_SELECT];

    // Effective configuration: pins in hardware mode (sense select held low), register otherwise (clear pin still ORed in)
    wire [3:0] eff_range = mode_hw_r ? s_range : c_range;
    wire eff_oen = mode_hw_r ? s_oen : c_oen;
    wire eff_clr = mode_hw_r ? s_clr : (s_clr | c_clr);
    wire eff_cls = mode_hw_r ? s_cls : c_cls;
    wire eff_sense_resistor_select = mode_hw_r ? 1'b0 : c_sense_resistor_select;

    // Channel follows the range code, so no code can select both
    wire is_v = (eff_range == `OMP_RNG_V5) | (eff_range == `OMP_RNG_V10) | (eff_range == `OMP_RNG_V40);
    wire is_i = (eff_range == `OMP_RNG_I4_20) | (eff_range == `OMP_RNG_I0_20) | (eff_range == `OMP_RNG_I0_24);

    // Reset pin and power-up hold apply only in software mode
    wire in_reset = captured_r & ~mode_hw_r & ~s_rst_n;
    wire in_pwrup = captured_r & ~mode_hw_r & ~started_r;
    wire run = captured_r & ~in_pwrup & ~in_reset & eff_oen;

    // Output stage next values
    wire voltage_output_pin_nxt = in_pwrup ? pwrup_clr_r : (run & is_v);
    wire vzero_nxt = in_pwrup & pwrup_clr_r;
    wire current_output_pin_nxt = run & is_i & ~is_v;
    wire clrst_nxt = run & eff_clr & (is_v | is_i);

    // Bus decode
    wire do_wr = aw_got_r & w_got_r & ~bvalid_r;
    wire wr_ctrl = do_wr & (waddr_r == `OMP_CTRL_ADDR);
    wire wr_ok = wr_ctrl | (do_wr & (waddr_r == `OMP_STAT_ADDR));
    // Writes that land while the reset pin holds the block are dropped
    wire sw_wr = wr_ctrl & ~mode_hw_r & captured_r & ~in_reset & (&wstrb_r);
    wire sw_rst = sw_wr & wdata_r[`OMP_F_RST];
    wire sw_start = sw_wr & wdata_r[`OMP_F_OEN] & ~wdata_r[`OMP_F_RST];
    wire [15:0] ctrl_nxt = wdata_r[15:0] & `OMP_CTRL_MASK;
    wire rd_go = s_axi_arvalid & ~rvalid_r;
    wire rd_ctrl = s_axi_araddr == `OMP_CTRL_ADDR;
    wire rd_stat = s_axi_araddr == `OMP_STAT_ADDR;
    wire [31:0] stat_word = {20'h0_0000, range_r, 2'h0, pwrup_clr_r, clrst_r, current_output_pin_r, voltage_output_pin_r, started_r, mode_hw_r};
    wire [31:0] rd_nxt = rd_ctrl ? {16'h0000, ctrl_r} : (rd_stat ? stat_word : 32'h0000_0000);

    // Straps are caught once the synchronisers hold real pin levels
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cap_cnt_r <= 2'h0;
            captured_r <= 1'b0;
            mode_hw_r <= 1'b0;
            pwrup_clr_r <= 1'b0;
        end
        else if (!captured_r)
        begin
            cap_cnt_r <= cap_cnt_r + 2'h1;
            if (cap_cnt_r == `OMP_CAPTURE_DLY)
            begin
                captured_r <= 1'b1;
                mode_hw_r <= s_mode;
                pwrup_clr_r <= s_clr;
            end
        end
        else if (in_reset | sw_rst)
        begin
            pwrup_clr_r <= s_clr; // Reset returns to the power-on condition
        end
    end

    // Control register and start flag
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_r <= `OMP_CTRL_RESET;
            started_r <= 1'b0;
        end
        else if (in_reset | sw_rst)
        begin
            ctrl_r <= `OMP_CTRL_RESET;
            started_r <= 1'b0;
        end
        else if (sw_wr)
        begin
            ctrl_r <= ctrl_nxt;
            started_r <= started_r | sw_start;
        end
    end

    // Registered output stage controls
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            voltage_output_pin_r <= 1'b0;
            vzero_r <= 1'b0;
            current_output_pin_r <= 1'b0;
            clrst_r <= 1'b0;
            range_r <= 4'h0;
            sense_resistor_select_r <= 1'b0;
        end
        else
        begin
            voltage_output_pin_r <= voltage_output_pin_nxt;
            vzero_r <= vzero_nxt | (clrst_nxt & ~eff_cls & is_v);
            current_output_pin_r <= current_output_pin_nxt;
            clrst_r <= clrst_nxt;
            range_r <= eff_range;
            sense_resistor_select_r <= eff_sense_resistor_select;
        end
    end

    // Write channel: address and data taken in either order
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            waddr_r <= 4'h0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= `OMP_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid & s_axi_awready)
            begin
                aw_got_r <= 1'b1;
                waddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_wr)
            begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? `OMP_RESP_OKAY : `OMP_RESP_SLVERR;
            end
            else if (bvalid_r & s_axi_bready)
            begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Read channel: one cycle from address to data
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `OMP_RESP_OKAY;
        end
        else if (rd_go)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_nxt;
            rresp_r <= (rd_ctrl | rd_stat) ? `OMP_RESP_OKAY : `OMP_RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            rvalid_r <= 1'b0;
        end
    end

    // Port drive
    assign s_axi_awready = ~aw_got_r & ~bvalid_r;
    assign s_axi_wready = ~w_got_r & ~bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign voltage_output_pin = voltage_output_pin_r;
    assign voltage_zero = vzero_r;
    assign current_output_pin = current_output_pin_r;
    assign clear_state = clrst_r;
    assign out_range = range_r;
    assign sense_resistor_select = sense_resistor_select_r;
    assign mode_hw = mode_hw_r;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_excl;
        !(voltage_output_pin_r && current_output_pin_r);
    endproperty
    a_excl: assert property (p_excl) else $error("both channels on");

    property p_hw_range;
        (captured_r && mode_hw_r) |=> (range_r == $past(s_range));
    endproperty
    a_hw_range: assert property (p_hw_range) else $error("hw range not from pins");

    property p_sw_range;
        (captured_r && !mode_hw_r) |=> (range_r == $past(c_range));
    endproperty
    a_sw_range: assert property (p_sw_range) else $error("sw range not from register");

    property p_pwr_clr;
        (in_pwrup && pwrup_clr_r) |=> (voltage_output_pin_r && vzero_r && !current_output_pin_r);
    endproperty
    a_pwr_clr: assert property (p_pwr_clr) else $error("no 0 V drive at power-up");

    property p_pwr_hiz;
        (in_pwrup && !pwrup_clr_r) |=> (!voltage_output_pin_r && !current_output_pin_r);
    endproperty
    a_pwr_hiz: assert property (p_pwr_hiz) else $error("channel driven at power-up");

    property p_oen_off;
        (captured_r && !in_pwrup && !eff_oen) |=> (!voltage_output_pin_r && !current_output_pin_r);
    endproperty
    a_oen_off: assert property (p_oen_off) else $error("driven while disabled");

    property p_mode_hold;
        captured_r |=> (captured_r && $stable(mode_hw_r));
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed");

    property p_rst_pin;
        // The voltage channel may only sit at its power-on 0 V drive
        in_reset |=> (ctrl_r == 16'h0000 && !started_r && !current_output_pin_r && (voltage_output_pin_r == vzero_r));
    endproperty
    a_rst_pin: assert property (p_rst_pin) else $error("reset pin not held");

    property p_rst_bit;
        sw_rst |=> (ctrl_r[`OMP_F_RST] == 1'b0 && ctrl_r == 16'h0000);
    endproperty
    a_rst_bit: assert property (p_rst_bit) else $error("reset bit stuck");

    property p_clr;
        (run && eff_clr && (is_v || is_i)) |=> clear_state;
    endproperty
    a_clr: assert property (p_clr) else $error("clear state missed");

    property p_start;
        sw_start |=> (started_r && !in_pwrup);
    endproperty
    a_start: assert property (p_start) else $error("enable write ignored");

    property p_first;
        $rose(captured_r) |-> (ctrl_r == 16'h0000 && !current_output_pin_r);
    endproperty
    a_first: assert property (p_first) else $error("nonzero after power-on");

    c_pwr_clr: cover property ((in_pwrup && pwrup_clr_r) ##1 voltage_output_pin_r);
    c_cur_run: cover property (started_r && current_output_pin_r);
    c_clear: cover property (clrst_r ##[1:20] !clrst_r);
    c_hw: cover property (mode_hw_r && voltage_output_pin_r);
endmodule

//--- src/omp_pkg.sv
// Types of the output mode control.
// Assumes omp_consts.svh is on the include path.
`include "omp_consts.svh"
package omp_pkg;
    typedef logic [3:0] omp_range_t;
    typedef logic [15:0] omp_ctrl_t;
endpackage

//--- test/omp_ctrl_tb_top.sv
// Self-checking bench of the output mode control, host model on bus and pins.
// Assumes outputs settle within four cycles of a pin change.
`timescale 1ns/1ns
`include "omp_consts.svh"
module omp_ctrl_tb_top;
    logic clk, nrst;
    logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr, range_select, out_range, code;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp, ch;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic mode_select_pin, output_enable, clear_pin, clear_level_select, reset_pin_n;
    logic voltage_output_pin, voltage_zero, current_output_pin, clear_state, sense_resistor_select, mode_hw;
    int fails, checks;
    logic [33:0] rd_q[$];
    logic [33:0] rd_e;

    omp_ctrl u_omp_ctrl (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .mode_select_pin, .range_select, .output_enable, .clear_pin, .clear_level_select,
        .reset_pin_n, .voltage_output_pin, .voltage_zero, .current_output_pin, .clear_state, .out_range,
        .sense_resistor_select, .mode_hw);
    omp_host u_omp_host (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .mode_select_pin, .range_select,
        .output_enable, .clear_pin, .clear_level_select, .reset_pin_n);

    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Outputs {vdrive, vzero, idrive, clear} and range, sampled mid-cycle
    task automatic chk_out(input logic [3:0] e, input logic [3:0] r);
        @(negedge clk);
        chk({28'h0, voltage_output_pin, voltage_zero, current_output_pin, clear_state}, {28'h0, e}, "outs");
        chk({28'h0, out_range}, {28'h0, r}, "range");
        @(posedge clk);
    endtask

    // Sense resistor select and caught mode, sampled mid-cycle
    task automatic chk_side(input logic rs, input logic hw);
        @(negedge clk);
        chk({31'h0, sense_resistor_select}, {31'h0, rs}, "sense");
        chk({31'h0, mode_hw}, {31'h0, hw}, "mode");
        @(posedge clk);
    endtask

    // Each read answer is matched against the oldest expectation
    always @(negedge clk)
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
        begin
            if (rd_q.size() == 0)
                chk(32'h0, 32'h1, "unexpected read");
            else
            begin
                rd_e = rd_q.pop_front();
                chk({30'h0, s_axi_rresp}, {30'h0, rd_e[33:32]}, "rresp");
                chk(s_axi_rdata, rd_e[31:0], "rdata");
            end
        end

    // Channel of a range code: {voltage, current}
    function automatic logic [1:0] chan(input logic [3:0] c);
        case (c)
            `OMP_RNG_V5, `OMP_RNG_V10, `OMP_RNG_V40: chan = 2'h2;
            `OMP_RNG_I4_20, `OMP_RNG_I0_20, `OMP_RNG_I0_24: chan = 2'h1;
            default: chan = 2'h0;
        endcase
    endfunction

    // Control word: range, clear level, enable, clear, sense, reset
    function automatic logic [31:0] cw(input logic [3:0] r, input logic cls, oe, clr, rs, rst);
        cw = {21'h0, r, cls, oe, clr, rs, rst, 2'h0};
    endfunction

    task automatic wr_ctrl(input logic [31:0] d);
        u_omp_host.wr(`OMP_CTRL_ADDR, d, resp);
        chk({30'h0, resp}, {30'h0, `OMP_RESP_OKAY}, "bresp");
        repeat (2) @(posedge clk);
    endtask

    task automatic rd_exp(input logic [3:0] a, input logic [1:0] r, input logic [31:0] d);
        rd_q.push_back({r, d});
        u_omp_host.rd(a);
    endtask

    task automatic do_reset;
        nrst <= 1'b0;
        repeat (16) @(posedge clk);
        chk_out(4'h0, 4'h0);
        nrst <= 1'b1;
        repeat (10) @(posedge clk);
    endtask

    task automatic end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // A hang is cut short well past the expected run length
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        end_sim();
    end

    initial
    begin
        fails = 0;
        checks = 0;
        nrst = 1'b0;
        void'($urandom(32'h7a40));
        // Software power-up, clear high: 0 V drive, current off
        u_omp_host.pins('0, 4'h0, '0, '1, '0, '1);
        do_reset();
        chk_out(4'hC, 4'h0);
        rd_exp(`OMP_CTRL_ADDR, `OMP_RESP_OKAY, 32'h0);
        wr_ctrl(cw(`OMP_RNG_V10, '0, '1, '0, '1, '0));
        chk_out(4'hD, `OMP_RNG_V10);
        chk_side(1'b1, 1'b0);
        u_omp_host.pins('0, 4'h0, '0, '0, '0, '1);
        repeat (4) @(posedge clk);
        chk_out(4'h8, `OMP_RNG_V10);
        rd_exp(`OMP_CTRL_ADDR, `OMP_RESP_OKAY, cw(`OMP_RNG_V10, '0, '1, '0, '1, '0));
        // Status: range, caught clear pin high, voltage drive, started, software mode
        rd_exp(`OMP_STAT_ADDR, `OMP_RESP_OKAY, {20'h0_0000, `OMP_RNG_V10, 8'h26});
        // Every range code, enable and range in one write
        for (int c = 0; c < 16; c++)
        begin
            ch = chan(c[3:0]);
            wr_ctrl(cw(c[3:0], 1'($urandom), '1, '0, '0, '0));
            chk_out({ch[1], 1'b0, ch[0], 1'b0}, c[3:0]);
        end
        wr_ctrl(cw(`OMP_RNG_I0_20, '0, '0, '0, '0, '0));
        chk_out(4'h0, `OMP_RNG_I0_20);
        wr_ctrl(cw(`OMP_RNG_V5, '1, '1, '1, '0, '0));
        chk_out(4'h9, `OMP_RNG_V5);
        // Reset bit wins over enable and clears itself
        wr_ctrl(cw(`OMP_RNG_I4_20, '0, '1, '0, '0, '1));
        chk_out(4'h0, 4'h0);
        rd_exp(`OMP_CTRL_ADDR, `OMP_RESP_OKAY, 32'h0);
        // Reset pin held low keeps everything off
        wr_ctrl(cw(`OMP_RNG_I0_24, '0, '1, '0, '0, '0));
        chk_out(4'h2, `OMP_RNG_I0_24);
        u_omp_host.pins('0, 4'h0, '0, '0, '0, '0);
        repeat (8) @(posedge clk);
        chk_out(4'h0, 4'h0);
        repeat (8) @(posedge clk);
        chk_out(4'h0, 4'h0);
        u_omp_host.pins('0, 4'h0, '0, '0, '0, '1);
        rd_exp(4'h8, `OMP_RESP_SLVERR, 32'h0);
        // Software power-up, clear low: both channels tristate
        do_reset();
        chk_out(4'h0, 4'h0);
        // Hardware power-up with enable pin low
        u_omp_host.pins('1, `OMP_RNG_I0_24, '0, '0, '0, '1);
        do_reset();
        chk_out(4'h0, `OMP_RNG_I0_24);
        wr_ctrl(cw(`OMP_RNG_V5, '0, '1, '0, '1, '0));
        rd_exp(`OMP_CTRL_ADDR, `OMP_RESP_OKAY, 32'h0);
        chk_side(1'b0, 1'b1);
        // Random pin ranges; mode pin toggles but the caught mode holds
        for (int k = 0; k < 8; k++)
        begin
            code = 4'($urandom);
            ch = chan(code);
            u_omp_host.pins(k[0], code, '1, '0, '0, '1);
            repeat (4) @(posedge clk);
            chk_out({ch[1], 1'b0, ch[0], 1'b0}, code);
            chk_side(1'b0, 1'b1);
        end
        u_omp_host.pins('1, `OMP_RNG_V10, '1, '1, '0, '1);
        repeat (4) @(posedge clk);
        chk_out(4'hD, `OMP_RNG_V10);
        end_sim();
    end
endmodule

//--- test/omp_host.sv
// Host model: drives the configuration pins and masters the AXI4-Lite bus.
// Assumes callers enter its tasks just after a rising clk edge.
`timescale 1ns/1ns
module omp_host
(
    // Clock
    input wire logic clk,
    // Write channels
    output logic [3:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    // Read channels
    output logic [3:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready,
    // Configuration pins
    output logic mode_select_pin,
    output logic [3:0] range_select,
    output logic output_enable,
    output logic clear_pin,
    output logic clear_level_select,
    output logic reset_pin_n
);
    // Idle bus and released reset pin from time zero
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {mode_select_pin, range_select, output_enable, clear_pin, clear_level_select} = '0;
        reset_pin_n = 1'b1;
    end

    // All pins move together, right after an edge
    task automatic pins(input logic m, input logic [3:0] r, input logic oe, input logic clr,
        input logic cls, input logic rn);
        mode_select_pin <= m;
        range_select <= r;
        output_enable <= oe;
        clear_pin <= clr;
        clear_level_select <= cls;
        reset_pin_n <= rn;
    endtask

    // Ready is sampled mid-cycle; it cannot move before the next edge.
    // Released address and data are inverted (strobes stay set) so stale values are never mistaken for live ones.
    task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic aw_t, w_t, b_t;
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_wstrb <= 4'hF;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            b_t = 1'b0;
            while (!b_t)
            begin
                @(negedge clk);
                aw_t = s_axi_awvalid & s_axi_awready;
                w_t = s_axi_wvalid & s_axi_wready;
                b_t = s_axi_bvalid;
                resp = s_axi_bresp;
                @(posedge clk);
                if (aw_t) s_axi_awvalid <= 1'b0;
                if (aw_t) s_axi_awaddr <= ~a;
                if (w_t) s_axi_wvalid <= 1'b0;
                if (w_t) s_axi_wdata <= ~d;
            end
            s_axi_bready <= 1'b0;
            @(posedge clk);
        end
    endtask

    // One read; the bench monitor judges the returned word
    task automatic rd(input logic [3:0] a);
        logic ar_t, r_t;
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            r_t = 1'b0;
            while (!r_t)
            begin
                @(negedge clk);
                ar_t = s_axi_arvalid & s_axi_arready;
                r_t = s_axi_rvalid;
                @(posedge clk);
                if (ar_t) s_axi_arvalid <= 1'b0;
                if (ar_t) s_axi_araddr <= ~a;
            end
            s_axi_rready <= 1'b0;
            @(posedge clk);
        end
    endtask
endmodule
